// [rtl/mpg_consts.vh]
// constants for the multimode pulse edge generator
`ifndef MPG_CONSTS_VH
`define MPG_CONSTS_VH
`define MPG_MODE_NORMAL 3'h0
`define MPG_MODE_MULTI 3'h1
`define MPG_MODE_RESON 3'h2
`define MPG_MODE_TRIANG 3'h3
`define MPG_MODE_LEAD 3'h4
`define MPG_A_EVENT1 4'h0
`define MPG_A_EVENT2 4'h1
`define MPG_A_EVENT3 4'h2
`define MPG_A_EVENT4 4'h3
`define MPG_A_CYCADJ_A 4'h4
`define MPG_A_CYCADJ_B 4'h5
`define MPG_A_DT_ADJ 4'h6
`define MPG_A_SAMP_OFS 4'h7
`define MPG_A_PH_TRIG 4'h8
`define MPG_A_BLANK_A_BEG 4'h9
`define MPG_A_BLANK_A_END 4'ha
`define MPG_A_BLANK_B_BEG 4'hb
`define MPG_A_BLANK_B_END 4'hc
`define MPG_A_PERIOD 4'hd
`define MPG_A_CTRL 4'he
`define MPG_A_STATUS 4'hf
`define MPG_CTRL_MODE_LSB 0
`define MPG_CTRL_MODE_MSB 2
`define MPG_CTRL_EN_BIT 3
`define MPG_CTRL_PHSEL_BIT 4
`define MPG_PERIOD_RST 16'h00ff
`define MPG_HTRANS_NONSEQ_BIT 1
`define MPG_WORD_ADDR_LSB 2
`define MPG_WORD_ADDR_MSB 5
`endif

// [rtl/mpg_top.v]
// multimode pulse edge generator with ahb-lite register slave
`timescale 1ns/10ps
`include "mpg_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - period counter runs 0 to period limit, wraps to zero, repeats.
// - each output changes in the cycle after the counter equals its target.
// - normal mode: duty sets A width, B fills rest after dead time.
// - normal: A rises at event1, falls event1+duty+cycle adjust A.
// - normal: B rises at A fall plus (ev3-ev2), falls ev4+dead adjust.
// - cycle adjust B is ignored in normal mode.
// - sample triggers at ev1+duty+offset and ev1+duty/2+offset.
// - phase trigger from register or filter duty, by config bit.
// - multi: A falls ev1+duty+adjA+dt; B ev3 to ev3+duty+adjB+dt.
// - multi mode uses neither event 2 nor event 4.
// - multi: B may wrap past period end; A cannot.
// - multi: cycle adjust B sets B width independently.
// - resonant: mean dead time subtracted from duty for both outputs.
// - resonant: A ev1 to duty-ev1, B duty+ev1 to period-ev1.
// - triangular: no A edges, no adaptive sample triggers.
// - triangular: B from per/2-duty/2+adjA to per/2+duty/2+adjB.
// - leading: A rising fixed at ev1, falling moves earlier with duty.
// - leading: B rises ev4, falls ev1-duty+adjA-(ev2-ev3).
// - leading: triggers at ev1-duty+offset and ev1-duty/2+offset.
// - programmable blanking windows A and B, begin and end.
module mpg_top #(
  parameter CW = 16
) (
  input wire clk_sys_i, // 40 mhz core clock
  input wire nrst_i, // async reset, active low
  input wire clk_en_i, // freezes all state when low
  input wire srst_i, // synchronous reset of counter and outputs
  input wire [CW-1:0] filt_duty_i, // loop filter duty
  input wire [CW-1:0] filt_period_i, // loop filter period
  input wire hsel_i, // ahb select
  input wire [31:0] haddr_i, // ahb address
  input wire [1:0] htrans_i, // ahb transfer type
  input wire hwrite_i, // ahb write
  input wire [2:0] hsize_i, // ahb size
  input wire [31:0] hwdata_i, // ahb write data
  input wire hready_i, // ahb bus ready
  output reg [31:0] hrdata_o, // ahb read data
  output reg hreadyout_o, // ahb slave ready
  output reg hresp_o, // ahb response, always okay
  output reg pulse_out_a_o, // gate drive a
  output reg pulse_out_b_o, // gate drive b
  output reg samp_trig_a_o, // adaptive sample trigger a pulse
  output reg samp_trig_b_o, // adaptive sample trigger b pulse
  output reg phase_trig_o, // phase trigger pulse
  output reg blank_a_o, // blanking window a
  output reg blank_b_o // blanking window b
);
////////////////////////////////////////////////////////////////////////////////
reg [CW-1:0] cnt_q;
reg [CW-1:0] ev1_q, ev2_q, ev3_q, ev4_q, adja_q, adjb_q, dt_q, sofs_q, ph_q;
reg [CW-1:0] bab_q, bae_q, bbb_q, bbe_q, per_q;
reg [4:0] ctrl_q;
reg wr_pend_q;
reg [3:0] wr_idx_q;
reg [CW-1:0] duty_q, fper_q;
wire [2:0] mode = ctrl_q[`MPG_CTRL_MODE_MSB:`MPG_CTRL_MODE_LSB];
wire run = ctrl_q[`MPG_CTRL_EN_BIT];

function [CW-1:0] wrapc;
  input [CW:0] v;
  input [CW-1:0] lim;
  begin
    // fold a target past the period end back into the period
    if (v > {1'b0, lim}) begin
      wrapc = v[CW-1:0] - lim - {{(CW-1){1'b0}}, 1'b1};
    end else begin
      wrapc = v[CW-1:0];
    end
  end
endfunction
////////////////////////////////////////////////////////////////////////////////
// ahb-lite slave: zero wait states, writes commit in the data phase
wire acc = hsel_i & hready_i & htrans_i[`MPG_HTRANS_NONSEQ_BIT];
wire [3:0] aidx = haddr_i[`MPG_WORD_ADDR_MSB:`MPG_WORD_ADDR_LSB];
reg [31:0] rd_mux;
always @* begin
  case (aidx)
    `MPG_A_EVENT1: rd_mux = {{(32-CW){1'b0}}, ev1_q};
    `MPG_A_EVENT2: rd_mux = {{(32-CW){1'b0}}, ev2_q};
    `MPG_A_EVENT3: rd_mux = {{(32-CW){1'b0}}, ev3_q};
    `MPG_A_EVENT4: rd_mux = {{(32-CW){1'b0}}, ev4_q};
    `MPG_A_CYCADJ_A: rd_mux = {{(32-CW){1'b0}}, adja_q};
    `MPG_A_CYCADJ_B: rd_mux = {{(32-CW){1'b0}}, adjb_q};
    `MPG_A_DT_ADJ: rd_mux = {{(32-CW){1'b0}}, dt_q};
    `MPG_A_SAMP_OFS: rd_mux = {{(32-CW){1'b0}}, sofs_q};
    `MPG_A_PH_TRIG: rd_mux = {{(32-CW){1'b0}}, ph_q};
    `MPG_A_BLANK_A_BEG: rd_mux = {{(32-CW){1'b0}}, bab_q};
    `MPG_A_BLANK_A_END: rd_mux = {{(32-CW){1'b0}}, bae_q};
    `MPG_A_BLANK_B_BEG: rd_mux = {{(32-CW){1'b0}}, bbb_q};
    `MPG_A_BLANK_B_END: rd_mux = {{(32-CW){1'b0}}, bbe_q};
    `MPG_A_PERIOD: rd_mux = {{(32-CW){1'b0}}, per_q};
    `MPG_A_CTRL: rd_mux = {27'h0000000, ctrl_q};
    `MPG_A_STATUS: rd_mux = {{(32-CW){1'b0}}, cnt_q} | {30'h00000000, pulse_out_b_o, pulse_out_a_o} << CW;
    default: rd_mux = 32'h00000000;
  endcase
end

always @(posedge clk_sys_i or negedge nrst_i) begin
  if (!nrst_i) begin
    wr_pend_q <= 1'b0;
    wr_idx_q <= 4'h0;
    hrdata_o <= 32'h00000000;
    hreadyout_o <= 1'b1;
    hresp_o <= 1'b0;
    ev1_q <= {CW{1'b0}}; ev2_q <= {CW{1'b0}}; ev3_q <= {CW{1'b0}}; ev4_q <= {CW{1'b0}};
    adja_q <= {CW{1'b0}}; adjb_q <= {CW{1'b0}}; dt_q <= {CW{1'b0}}; sofs_q <= {CW{1'b0}};
    ph_q <= {CW{1'b0}}; bab_q <= {CW{1'b0}}; bae_q <= {CW{1'b0}};
    bbb_q <= {CW{1'b0}}; bbe_q <= {CW{1'b0}};
    per_q <= `MPG_PERIOD_RST;
    ctrl_q <= 5'h00;
  end else if (clk_en_i) begin
    wr_pend_q <= acc & hwrite_i;
    if (acc) begin
      wr_idx_q <= aidx;
    end
    if (acc & ~hwrite_i) begin
      hrdata_o <= rd_mux;
    end
    if (wr_pend_q) begin
      case (wr_idx_q)
        `MPG_A_EVENT1: ev1_q <= hwdata_i[CW-1:0];
        `MPG_A_EVENT2: ev2_q <= hwdata_i[CW-1:0];
        `MPG_A_EVENT3: ev3_q <= hwdata_i[CW-1:0];
        `MPG_A_EVENT4: ev4_q <= hwdata_i[CW-1:0];
        `MPG_A_CYCADJ_A: adja_q <= hwdata_i[CW-1:0];
        `MPG_A_CYCADJ_B: adjb_q <= hwdata_i[CW-1:0];
        `MPG_A_DT_ADJ: dt_q <= hwdata_i[CW-1:0];
        `MPG_A_SAMP_OFS: sofs_q <= hwdata_i[CW-1:0];
        `MPG_A_PH_TRIG: ph_q <= hwdata_i[CW-1:0];
        `MPG_A_BLANK_A_BEG: bab_q <= hwdata_i[CW-1:0];
        `MPG_A_BLANK_A_END: bae_q <= hwdata_i[CW-1:0];
        `MPG_A_BLANK_B_BEG: bbb_q <= hwdata_i[CW-1:0];
        `MPG_A_BLANK_B_END: bbe_q <= hwdata_i[CW-1:0];
        `MPG_A_PERIOD: per_q <= hwdata_i[CW-1:0];
        `MPG_A_CTRL: ctrl_q <= hwdata_i[4:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end
end
////////////////////////////////////////////////////////////////////////////////
// period counter; filter inputs latched at period start so edges stay consistent
wire at_end = (cnt_q == per_q);
always @(posedge clk_sys_i or negedge nrst_i) begin
  if (!nrst_i) begin
    cnt_q <= {CW{1'b0}};
    duty_q <= {CW{1'b0}};
    fper_q <= {CW{1'b0}};
  end else if (clk_en_i) begin
    if (srst_i | ~run) begin
      cnt_q <= {CW{1'b0}};
    end else if (at_end) begin
      cnt_q <= {CW{1'b0}};
      duty_q <= filt_duty_i;
      fper_q <= filt_period_i;
    end else begin
      cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end
end
////////////////////////////////////////////////////////////////////////////////
// edge targets per mode
reg [CW-1:0] a_on, a_off, b_on, b_off, sa, sb;
reg a_en, s_en, b_wrap;
wire [CW-1:0] half_d = {1'b0, duty_q[CW-1:1]};
wire [CW-1:0] afall_n = ev1_q + duty_q + adja_q;
// the two dead times are the a-fall to b-rise gap and the dead-time adjustment
wire [CW-1:0] gap_ab = ev3_q - ev2_q;
wire [CW:0] dt_sum = {1'b0, gap_ab} + {1'b0, dt_q};
wire [CW-1:0] dt_mean = dt_sum[CW:1];
wire [CW-1:0] rduty = duty_q - dt_mean;
always @* begin
  a_en = 1'b1;
  s_en = 1'b1;
  b_wrap = 1'b0;
  a_on = ev1_q;
  a_off = afall_n;
  b_on = afall_n + (ev3_q - ev2_q);
  b_off = ev4_q + dt_q;
  sa = ev1_q + duty_q + sofs_q;
  sb = ev1_q + half_d + sofs_q;
  case (mode)
    `MPG_MODE_NORMAL: begin
      a_en = 1'b1;
    end
    `MPG_MODE_MULTI: begin
      // events 2 and 4 unused here
      a_off = afall_n + dt_q;
      b_on = ev3_q;
      b_off = wrapc({1'b0, ev3_q} + {1'b0, duty_q} + {1'b0, adjb_q} + {1'b0, dt_q}, per_q);
      b_wrap = 1'b1;
    end
    `MPG_MODE_RESON: begin
      a_off = rduty - ev1_q;
      b_on = duty_q + ev1_q;
      b_off = fper_q - dt_mean - ev1_q;
    end
    `MPG_MODE_TRIANG: begin
      a_en = 1'b0;
      s_en = 1'b0;
      b_on = {1'b0, fper_q[CW-1:1]} - half_d + adja_q;
      b_off = {1'b0, fper_q[CW-1:1]} + half_d + adjb_q;
    end
    `MPG_MODE_LEAD: begin
      a_off = ev1_q - duty_q + adja_q;
      b_on = ev4_q;
      b_off = ev1_q - duty_q + adja_q - (ev2_q - ev3_q);
      sa = ev1_q - duty_q + sofs_q;
      sb = ev1_q - half_d + sofs_q;
    end
    default: begin
      a_en = 1'b0;
      s_en = 1'b0;
    end
  endcase
end
// in resonant mode the difference of dead times is not used; only their mean
wire [CW-1:0] ph_pos = ctrl_q[`MPG_CTRL_PHSEL_BIT] ? duty_q : ph_q;
////////////////////////////////////////////////////////////////////////////////
// outputs change in the cycle after a counter match; a late b edge may carry over the wrap
always @(posedge clk_sys_i or negedge nrst_i) begin
  if (!nrst_i) begin
    pulse_out_a_o <= 1'b0;
    pulse_out_b_o <= 1'b0;
    samp_trig_a_o <= 1'b0;
    samp_trig_b_o <= 1'b0;
    phase_trig_o <= 1'b0;
    blank_a_o <= 1'b0;
    blank_b_o <= 1'b0;
  end else if (clk_en_i) begin
    if (srst_i | ~run) begin
      pulse_out_a_o <= 1'b0;
      pulse_out_b_o <= 1'b0;
      samp_trig_a_o <= 1'b0;
      samp_trig_b_o <= 1'b0;
      phase_trig_o <= 1'b0;
      blank_a_o <= 1'b0;
      blank_b_o <= 1'b0;
    end else begin
      if (!a_en) begin
        pulse_out_a_o <= 1'b0;
      end else if (cnt_q == a_off) begin
        pulse_out_a_o <= 1'b0;
      end else if (cnt_q == a_on) begin
        pulse_out_a_o <= 1'b1;
      end else if (at_end && !(mode == `MPG_MODE_LEAD)) begin
        pulse_out_a_o <= 1'b0;
      end
      if (cnt_q == b_off) begin
        pulse_out_b_o <= 1'b0;
      end else if (cnt_q == b_on) begin
        pulse_out_b_o <= 1'b1;
      end else if (at_end && !b_wrap && mode != `MPG_MODE_LEAD) begin
        pulse_out_b_o <= 1'b0;
      end
      samp_trig_a_o <= s_en & (cnt_q == sa);
      samp_trig_b_o <= s_en & (cnt_q == sb);
      phase_trig_o <= (cnt_q == ph_pos);
      if (cnt_q == bae_q) begin
        blank_a_o <= 1'b0;
      end else if (cnt_q == bab_q) begin
        blank_a_o <= 1'b1;
      end
      if (cnt_q == bbe_q) begin
        blank_b_o <= 1'b0;
      end else if (cnt_q == bbb_q) begin
        blank_b_o <= 1'b1;
      end
    end
  end
end

endmodule // mpg_top

// [sim/mpg_gate_model.sv]
// gate driver model: measures on-times of a drive pair and the a-fall to b-rise gap
`timescale 1ns/10ps
module mpg_gate_model (
  input wire logic clk_i, // core clock
  input wire logic nrst_i, // async reset, active low
  input wire logic gate_a_i, // drive a
  input wire logic gate_b_i, // drive b
  output logic [15:0] width_a_o, // last a on-time in cycles
  output logic [15:0] width_b_o, // last b on-time in cycles
  output logic [15:0] gap_ab_o // last a fall to b rise
);
  logic [15:0] ca_q, cb_q, cg_q;
  logic a_q, b_q;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {ca_q, cb_q, cg_q, a_q, b_q, width_a_o, width_b_o, gap_ab_o} <= '0;
    end else begin
      a_q <= gate_a_i;
      b_q <= gate_b_i;
      ca_q <= gate_a_i ? ca_q + 16'h1 : 16'h0;
      cb_q <= gate_b_i ? cb_q + 16'h1 : 16'h0;
      cg_q <= (a_q && !gate_a_i) ? 16'h1 : cg_q + 16'h1;
      if (a_q && !gate_a_i) width_a_o <= ca_q;
      if (b_q && !gate_b_i) width_b_o <= cb_q;
      if (!b_q && gate_b_i) gap_ab_o <= cg_q;
    end
  end
endmodule // mpg_gate_model

// [sim/mpg_top_monitor.sv]
// port assertions for the multimode pulse edge generator
`timescale 1ns/10ps
`include "mpg_consts.vh"
module mpg_top_monitor (
  input wire clk_sys_i, // clock
  input wire nrst_i, // reset
  input wire clk_en_i, // clock enable
  input wire srst_i, // sync reset
  input wire hsel_i, // select
  input wire [31:0] haddr_i, // address
  input wire [1:0] htrans_i, // transfer type
  input wire hwrite_i, // write
  input wire [31:0] hwdata_i, // write data
  input wire hreadyout_o, // ready
  input wire hresp_o, // response
  input wire pulse_out_a_o, // drive a
  input wire pulse_out_b_o, // drive b
  input wire samp_trig_a_o, // trigger a
  input wire samp_trig_b_o, // trigger b
  input wire phase_trig_o // phase trigger
);
  logic wr_q;
  logic [3:0] wa_q;
  logic [3:0] ctl_q;
  wire quiet = !pulse_out_a_o && !pulse_out_b_o && !samp_trig_a_o && !samp_trig_b_o && !phase_trig_o;
  // ctrl is not visible at the ports, so enable and mode are shadowed from bus writes
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= 1'b0;
      wa_q <= 4'h0;
      ctl_q <= 4'h0;
    end else if (clk_en_i) begin
      wr_q <= hsel_i && htrans_i[1] && hwrite_i;
      wa_q <= haddr_i[5:2];
      if (wr_q && wa_q == `MPG_A_CTRL) ctl_q <= hwdata_i[3:0];
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  chk_bus_okay: assert property (hreadyout_o && !hresp_o) else $error("slave stalled or errored");
  chk_off_quiet: assert property ((!ctl_q[3] && clk_en_i)[*3] |-> quiet) else $error("output while off");
  chk_srst_quiet: assert property ((srst_i && clk_en_i)[*3] |-> quiet) else $error("output in reset");
  chk_trig_a_pulse: assert property (samp_trig_a_o && clk_en_i |=> !samp_trig_a_o) else $error("trig a long");
  chk_trig_b_pulse: assert property ($rose(samp_trig_b_o) && clk_en_i |=> $fell(samp_trig_b_o))
    else $error("trig b long");
  chk_phase_pulse: assert property (phase_trig_o && clk_en_i |=> !phase_trig_o) else $error("phase long");
  chk_freeze_hold: assert property (!clk_en_i |=> $stable(pulse_out_a_o) && $stable(pulse_out_b_o))
    else $error("moved while frozen");
  chk_tri_no_trig: assert property ((ctl_q == {1'b1, `MPG_MODE_TRIANG})[*3] |-> !samp_trig_a_o && !samp_trig_b_o)
    else $error("trigger in triangular");
  cover property (samp_trig_a_o);
  cover property (ctl_q == {1'b1, `MPG_MODE_LEAD} && pulse_out_b_o);
  cover property ($fell(pulse_out_a_o) ##[1:40] $rose(pulse_out_b_o));
endmodule // mpg_top_monitor
bind mpg_top mpg_top_monitor i_mon (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i), .srst_i(srst_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pulse_out_a_o(pulse_out_a_o), .pulse_out_b_o(pulse_out_b_o),
  .samp_trig_a_o(samp_trig_a_o), .samp_trig_b_o(samp_trig_b_o), .phase_trig_o(phase_trig_o));

// [sim/tb.sv]
// self-checking bench for the multimode pulse edge generator
`timescale 1ns/10ps
`include "mpg_consts.vh"
module tb;
  logic clk_sys_i = 1'b0;
  logic nrst_i, clk_en_i, srst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, pa, pb, sa, sb, ph, ba, bb;
  logic a_d = 1'b0;
  logic [15:0] filt_duty_i, filt_period_i, duty, adjb, wa, wb, gab, bwa, bwb, ta, tt, tp, na0;
  logic [15:0] sc = 16'h0;
  logic [15:0] na = 16'h0;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  integer seed, n_errors, check_count;
  integer cyc = 0;
  // event1..4, adjust a/b, dead adjust, sample offset, phase reg, blank a/b begin/end
  logic [15:0] rv [0:12] = '{16'd10, 16'd20, 16'd26, 16'd180, 16'd4, 16'd7, 16'd3, 16'd5, 16'd60, 16'd2, 16'd9,
    16'd150, 16'd158};
  mpg_top #(.CW(16)) i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i), .srst_i(srst_i),
    .filt_duty_i(filt_duty_i), .filt_period_i(filt_period_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pulse_out_a_o(pa), .pulse_out_b_o(pb),
    .samp_trig_a_o(sa), .samp_trig_b_o(sb), .phase_trig_o(ph), .blank_a_o(ba), .blank_b_o(bb));
  mpg_gate_model i_gate (.clk_i(clk_sys_i), .nrst_i(nrst_i), .gate_a_i(pa), .gate_b_i(pb), .width_a_o(wa),
    .width_b_o(wb), .gap_ab_o(gab));
  mpg_gate_model i_blank (.clk_i(clk_sys_i), .nrst_i(nrst_i), .gate_a_i(ba), .gate_b_i(bb), .width_a_o(bwa),
    .width_b_o(bwb), .gap_ab_o());
  always #12.5 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////////////////////////
  // trigger positions are measured from the a rising edge, which sits at event 1
  always @(posedge clk_sys_i) begin
    a_d <= pa;
    na <= na + {15'h0, pa};
    sc <= (pa && !a_d) ? 16'h1 : sc + 16'h1;
    if (sa) ta <= sc;
    if (sb) tt <= sc;
    if (ph) tp <= sc;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // waits on hready with no assumed latency; the cycle ceiling ends a hang
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask
  function automatic logic [15:0] exp_b(input logic [2:0] m, input logic [15:0] d, input logic [15:0] b);
    case (m)
      `MPG_MODE_NORMAL: return rv[3] + rv[6] - (rv[0] + d + rv[4] + rv[2] - rv[1]);
      `MPG_MODE_MULTI: return d + b + rv[6];
      default: return d + b - rv[4];
    endcase
  endfunction
  task automatic run_mode(input logic [2:0] m);
    duty = 16'd40 + 16'(2 * ($random(seed) & 15));
    adjb = 16'($random(seed) & 15);
    filt_duty_i <= duty;
    filt_period_i <= duty << 1;
    bus(1'b1, 32'h14, {16'h0, adjb}, rd);
    bus(1'b1, 32'h38, {27'h0, m[0], 1'b1, m}, rd);
    repeat (450) @(posedge clk_sys_i);
    na0 = na;
    repeat (450) @(posedge clk_sys_i);
    case (m)
      `MPG_MODE_NORMAL: begin
        check(wa, duty + rv[4]);
        check(wb, exp_b(m, duty, adjb));
        check(gab, rv[2] - rv[1]);
        check(tp, rv[8] - rv[0]);
        check(bwa, rv[10] - rv[9]);
        check(bwb, rv[12] - rv[11]);
      end
      `MPG_MODE_MULTI: begin
        check(wa, duty + rv[4] + rv[6]);
        check(wb, exp_b(m, duty, adjb));
        check(tp, duty - rv[0]);
      end
      `MPG_MODE_RESON: begin
        check(wa, wb);
        check(wa, duty - ((rv[2] - rv[1] + rv[6]) >> 1) - 16'(2 * rv[0]));
      end
      `MPG_MODE_TRIANG: begin
        check(wb, exp_b(m, duty, adjb));
        check(na - na0, 16'h0);
      end
      default: ;
    endcase
    if (m < `MPG_MODE_RESON) begin
      check(ta, duty + rv[7]);
      check(tt, (duty >> 1) + rv[7]);
    end
    $display("mode %0d done, duty %0d", m, duty);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h5217;
    n_errors = 0;
    check_count = 0;
    {nrst_i, clk_en_i, srst_i, hsel_i, hwrite_i} = 5'b01000;
    {haddr_i, hwdata_i, htrans_i} = '0;
    hsize_i = 3'b010;
    filt_duty_i = 16'd40;
    filt_period_i = 16'd80;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    bus(1'b0, 32'h34, 32'h0, rd);
    check(rd[15:0], 16'h00ff);
    bus(1'b0, 32'h38, 32'h0, rd);
    check(rd[15:0], 16'h0);
    for (int i = 0; i < 13; i++) bus(1'b1, 32'(4 * i), {16'h0, rv[i]}, rd);
    bus(1'b1, 32'h1c, 32'hffff_ffff, rd);
    bus(1'b0, 32'h5c, 32'h0, rd);
    check(rd[31:16], 16'h0);
    check(rd[15:0], 16'hffff);
    bus(1'b1, 32'h1c, {16'h0, rv[7]}, rd);
    bus(1'b1, 32'h34, 32'd199, rd);
    for (int m = 0; m < 5; m++) run_mode(3'(m));
    srst_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    check({14'h0, pa, pb}, 16'h0);
    srst_i <= 1'b0;
    clk_en_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    clk_en_i <= 1'b1;
    repeat (50) @(posedge clk_sys_i);
    final_report();
  end
endmodule // tb
